// ===== dcc_regs.svh
// Contract
// [R1] channel latch code selects string tap
// [R2] amplifier gain six or four by bit
// [R3] channels 0-3 group A, 4-7 group B
// [R4] per-channel zero and gain registers
// [R5] writes recompute corrected value when enabled
// [R6] one engine serves channels in turn
// [R7] enable bit on/off, off writes direct
// [R8] disabled gain/zero writes only store
// [R9] code times (gain+2^13)/2^14 plus zero
// [R10] gain 0.5 to 1.5, zero +-8192
// [R11] raw code from input or dac register
// [R12] group level uses code and offset code
// [R13] single supply holds offset converters down
// [R14] offset defaults 9830 or 10923
// [R15] reset gain 8192, zero 0, input 0
// [R16] format pin selects binary or twos complement
// [R17] bipolar binary 2000h is zero
// [R18] bipolar twos complement 0000h is zero
// [R19] unipolar binary 0000h is zero volts
// [R20] unipolar twos complement 2000h zero volts
// [R21] gain binary, zero twos complement always
// [R22] read-back in written format
// [R23] gain change reloads offset defaults
// [R24] corrected result saturates to 14 bits
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
`define DCC_CODE_W 14
`define DCC_NCH 8
`define DCC_OFF_CFG 12'h000
`define DCC_OFF_STAT 12'h004
`define DCC_OFF_OFSA 12'h008
`define DCC_OFF_OFSB 12'h00C
`define DCC_OFF_IN 12'h100
`define DCC_OFF_DAC 12'h140
`define DCC_OFF_ZERO 12'h180
`define DCC_OFF_GAIN 12'h1C0
`define DCC_CFG_CEN 0
`define DCC_CFG_GSEL 1
`define DCC_CFG_SINGLE 2
`define DCC_GAIN_RST 14'h2000
`define DCC_GAIN_BIAS 15'h2000
`define DCC_OFS6_RST 14'h2666
`define DCC_OFS4_RST 14'h2AAB
`define DCC_MSB_FLIP 14'h2000
`endif

// ===== dcc_pkg.sv
package dcc_pkg;
    typedef enum logic [1:0] {
        DCC_IDLE = 2'b01,
        DCC_CALC = 2'b10
    } dcc_state_type;
    typedef struct packed {
        logic [7:0][13:0] in_code;
        logic [7:0][13:0] dac_code;
        logic [7:0][13:0] zero;
        logic [7:0][13:0] gain;
        logic [1:0][13:0] ofs_code;
        logic cen;
        logic gsel;
        logic single;
        logic [7:0] pend;
        logic [2:0] ch;
        dcc_state_type st;
        logic [31:0] prdata;
        logic pready;
        logic [7:0][13:0] latch;
    } dcc_state_s_type;
endpackage : dcc_pkg

// ===== dcc_core.sv
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "dcc_regs.svh"
module dcc_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic number_format_pin,
    input wire logic load_strobe,
    output logic [7:0][13:0] latch_code,
    output logic [1:0][13:0] group_offset_code,
    output logic [1:0] offset_powered,
    output logic gain_is_six,
    output logic [7:0] group_b_map
);
    dcc_pkg::dcc_state_s_type s_q, s_d;
    logic fmt_m, fmt_q, ld_m, ld_q;
    logic wr, rd, hit;
    logic [2:0] idx;
    logic [13:0] wcode, rraw;
    logic [28:0] prod;
    logic signed [16:0] sum;
    logic [13:0] sat;
    logic [2:0] nxt;
    logic found;

    // pin-side inputs are asynchronous
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_m <= 1'b0;
            fmt_q <= 1'b0;
            ld_m <= 1'b0;
            ld_q <= 1'b0;
        end else begin
            fmt_m <= number_format_pin;
            fmt_q <= fmt_m;
            ld_m <= load_strobe;
            ld_q <= ld_m;
        end
    end

    // writes land only at the completing edge of the access phase
    assign wr = psel && penable && pwrite && s_q.pready;
    assign rd = psel && penable && !pwrite;
    assign idx = paddr[4:2];
    // twos complement codes are held offset binary internally
    assign wcode = fmt_q ? (pwdata[13:0] ^ `DCC_MSB_FLIP) : pwdata[13:0]; // see [R16]

    // engine math for the channel being served
    always_comb begin
        prod = 29'(s_q.in_code[s_q.ch]) * 29'({1'b0, s_q.gain[s_q.ch]} + `DCC_GAIN_BIAS); // see [R9]
        // quotient needs 15 bits: gain up to 1.5 overshoots the code range
        sum = 17'(signed'({2'b00, prod[28:14]})) + 17'(signed'(s_q.zero[s_q.ch])); // see [R10]
        if (sum < 0) begin
            sat = 14'h0000; // see [R24]
        end else if (sum > 17'sd16383) begin
            sat = 14'h3FFF; // see [R24]
        end else begin
            sat = sum[13:0];
        end
    end

    always_comb begin
        nxt = 3'd0;
        found = 1'b0;
        for (int i = 0; i < `DCC_NCH; i++) begin
            if (!found && s_q.pend[i]) begin
                nxt = 3'(i);
                found = 1'b1;
            end
        end
    end

    always_comb begin
        rraw = 14'h0000;
        hit = 1'b1;
        case (paddr[11:5])
            7'h08: rraw = s_q.in_code[idx] ^ (fmt_q ? `DCC_MSB_FLIP : 14'h0000); // see [R22]
            7'h0A: rraw = s_q.dac_code[idx] ^ (fmt_q ? `DCC_MSB_FLIP : 14'h0000); // see [R22]
            7'h0C: rraw = s_q.zero[idx]; // see [R21]
            7'h0E: rraw = s_q.gain[idx]; // see [R21]
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        s_d = s_q;
        // one wait state so registered read data stands at the ready edge
        s_d.pready = psel && penable && !s_q.pready;
        s_d.prdata = 32'h0000_0000;
        // engine: one channel per two cycles (pick, then calculate), pending writes queue
        unique case (s_q.st)
            dcc_pkg::DCC_IDLE: begin
                if (s_q.cen && found) begin
                    s_d.ch = nxt; // see [R6]
                    s_d.pend[nxt] = 1'b0;
                    s_d.st = dcc_pkg::DCC_CALC;
                end
            end
            dcc_pkg::DCC_CALC: begin
                s_d.dac_code[s_q.ch] = sat; // see [R5]
                s_d.st = dcc_pkg::DCC_IDLE;
            end
        endcase
        if (!s_q.cen) begin
            s_d.pend = 8'h00; // see [R8]
        end
        if (rd) begin
            if (paddr == `DCC_OFF_CFG) begin
                s_d.prdata = {29'h0000_0000, s_q.single, s_q.gsel, s_q.cen};
            end else if (paddr == `DCC_OFF_STAT) begin
                s_d.prdata = {23'h00_0000, s_q.st == dcc_pkg::DCC_CALC, s_q.pend};
            end else if (paddr == `DCC_OFF_OFSA || paddr == `DCC_OFF_OFSB) begin
                s_d.prdata = {18'h0_0000, s_q.ofs_code[paddr[2]] ^ (fmt_q ? `DCC_MSB_FLIP : 14'h0000)};
            end else if (hit) begin
                s_d.prdata = {18'h0_0000, rraw};
            end
        end
        if (wr) begin
            if (paddr == `DCC_OFF_CFG) begin
                s_d.cen = pwdata[`DCC_CFG_CEN]; // see [R7]
                s_d.gsel = pwdata[`DCC_CFG_GSEL]; // see [R2]
                s_d.single = pwdata[`DCC_CFG_SINGLE];
                if (pwdata[`DCC_CFG_GSEL] != s_q.gsel) begin
                    s_d.ofs_code[0] = pwdata[`DCC_CFG_GSEL] ? `DCC_OFS4_RST : `DCC_OFS6_RST; // see [R23]
                    s_d.ofs_code[1] = pwdata[`DCC_CFG_GSEL] ? `DCC_OFS4_RST : `DCC_OFS6_RST; // see [R23]
                end
            end else if (paddr == `DCC_OFF_OFSA || paddr == `DCC_OFF_OFSB) begin
                s_d.ofs_code[paddr[2]] = wcode; // see [R16]
            end else begin
                case (paddr[11:5])
                    7'h08: begin
                        s_d.in_code[idx] = wcode; // see [R11]
                        s_d.pend[idx] = s_q.cen; // see [R5]
                    end
                    7'h0A: begin
                        if (!s_q.cen) begin
                            s_d.dac_code[idx] = wcode; // see [R7]
                        end
                    end
                    7'h0C: begin
                        s_d.zero[idx] = pwdata[13:0]; // see [R21]
                        s_d.pend[idx] = s_q.cen; // see [R4]
                    end
                    7'h0E: begin
                        s_d.gain[idx] = pwdata[13:0]; // see [R21]
                        s_d.pend[idx] = s_q.cen; // see [R4]
                    end
                    default: ;
                endcase
            end
        end
        if (ld_q) begin
            s_d.latch = s_d.dac_code; // see [R1]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.in_code <= '0; // see [R15]
            s_q.dac_code <= '0;
            s_q.zero <= '0; // see [R15]
            s_q.gain <= {8{`DCC_GAIN_RST}}; // see [R15]
            s_q.ofs_code <= {2{`DCC_OFS6_RST}}; // see [R14]
            s_q.cen <= 1'b0;
            s_q.gsel <= 1'b0;
            s_q.single <= 1'b0;
            s_q.pend <= 8'h00;
            s_q.ch <= 3'd0;
            s_q.st <= dcc_pkg::DCC_IDLE;
            s_q.prdata <= 32'h0000_0000;
            s_q.pready <= 1'b0;
            s_q.latch <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // one wait state: pready rises in the second access cycle
    assign pready = s_q.pready && psel && penable;
    assign prdata = s_q.prdata;
    assign pslverr = 1'b0;
    assign latch_code = s_q.latch; // see [R1]
    // analog use of codes follows offset binary: see [R17] [R18] [R19] [R20] [R12]
    assign group_offset_code = s_q.single ? '0 : s_q.ofs_code; // see [R13]
    assign offset_powered = s_q.single ? 2'b00 : 2'b11; // see [R13]
    assign gain_is_six = !s_q.gsel; // see [R2]
    assign group_b_map = 8'hF0; // see [R3]
endmodule : dcc_core

// ===== dcc_core_chk.sv
`timescale 1ns/1ps
module dcc_core_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic number_format_pin,
    input wire logic load_strobe,
    input wire logic [7:0][13:0] latch_code,
    input wire logic [1:0][13:0] group_offset_code,
    input wire logic [1:0] offset_powered,
    input wire logic gain_is_six,
    input wire logic [7:0] group_b_map
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence cfg_wr;
        psel && penable && pready && pwrite && paddr == 12'h000;
    endsequence
    // four low samples cover the two sync flops plus margin
    sequence strobe_off;
        !load_strobe [*4];
    endsequence
    gain_sel_a: assert property (cfg_wr |=> gain_is_six == !$past(pwdata[1])) else $error("gain");
    group_map_a: assert property (group_b_map == 8'hF0) else $error("group map");
    supply_pwr_a:
        assert property (cfg_wr |=> offset_powered == {2{!$past(pwdata[2])}}) else $error("power");
    supply_code_a:
        assert property (offset_powered == 2'b00 |-> group_offset_code == '0) else $error("code");
    ofs_reload_a:
        assert property ($changed(gain_is_six) && offset_powered == 2'b11 |->
            group_offset_code == {2{gain_is_six ? 14'h2666 : 14'h2AAB}}) else $error("reload");
    ofs_reset_a:
        assert property (!$past(presetn) |-> group_offset_code == {2{14'h2666}}) else $error("ofs");
    latch_hold_a: assert property (strobe_off |=> $stable(latch_code)) else $error("hold");
    latch_reset_a: assert property (!$past(presetn) |-> latch_code == '0) else $error("latch");
endmodule : dcc_core_chk

// ===== dcc_host.sv
`timescale 1ns/1ps
module dcc_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    output logic [31:0] rd_data,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic rd_v,
    output logic hung
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rd_v, hung, rd_data} = '0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        hung <= (pready !== 1'b1);
        // read data is taken at the ready edge itself
        if (!w) begin
            rd_data <= prdata;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep looking valid
        paddr <= ~a;
        pwdata <= ~d;
        if (!w) begin
            @(posedge pclk);
            rd_v <= 1'b1;
            @(posedge pclk);
            rd_v <= 1'b0;
        end
    endtask : xfer
endmodule : dcc_host

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, strobe = 1'b1, fmt = 1'b0;
    logic [31:0] rdata;
    logic psel, penable, pwrite, pready, pslverr, six, rd_v, hung;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0][13:0] latch;
    logic [1:0][13:0] ofs;
    logic [1:0] pwr;
    logic [7:0] gmap;
    logic [31:0] expq[$];
    int fail_count = 0, checks = 0;
    dcc_host i_host (.pclk(pclk), .pready(pready), .prdata(prdata), .rd_data(rdata),
        .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rd_v(rd_v), .hung(hung));
    dcc_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .number_format_pin(fmt), .load_strobe(strobe),
        .latch_code(latch), .group_offset_code(ofs), .offset_powered(pwr),
        .gain_is_six(six), .group_b_map(gmap));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        i_host.xfer(1'b0, a, '0);
    endtask : rd
    initial forever #4 pclk = ~pclk;
    always @(negedge pclk) if (rd_v === 1'b1) check(rdata, expq.pop_front());
    always @(posedge hung) begin
        fail_count++;
        wrap_up();
    end
    initial begin
        logic [13:0] dv, gv, zv;
        int p;
        void'($urandom(32'h5089));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        strobe <= 1'b0;
        rd(12'h1C4, 32'h0000_2000);
        rd(12'h184, 32'h0000_0000);
        rd(12'h104, 32'h0000_0000);
        check(ofs, {14'h2666, 14'h2666});
        check(gmap, 32'h0000_00F0);
        strobe <= 1'b1;
        dv = 14'($urandom);
        gv = 14'($urandom);
        wr(12'h144, {18'h0, dv});
        wr(12'h1C8, {18'h0, gv});
        rd(12'h1C8, {18'h0, gv});
        check(latch[1], dv);
        check(latch[2], 32'h0000_0000);
        wr(12'h000, 32'h0000_0001);
        for (int ch = 3; ch < 8; ch++) begin
            dv = 14'($urandom);
            gv = 14'($urandom);
            zv = 14'($urandom);
            wr(12'h1C0 + 12'(4 * ch), {18'h0, gv});
            wr(12'h180 + 12'(4 * ch), {18'h0, zv});
            wr(12'h100 + 12'(4 * ch), {18'h0, dv});
            p = int'(dv) * (int'(gv) + 8192) / 16384 + int'($signed(zv));
            p = p < 0 ? 0 : (p > 16383 ? 16383 : p);
            rd(12'h100 + 12'(4 * ch), {18'h0, dv});
            check(latch[ch], p[13:0]);
            rd(12'h140 + 12'(4 * ch), {18'h0, p[13:0]});
        end
        wr(12'h000, 32'h0000_0002);
        @(negedge pclk);
        check(six, 32'h0000_0000);
        check(ofs, {14'h2AAB, 14'h2AAB});
        wr(12'h000, 32'h0000_0004);
        @(negedge pclk);
        check({pwr, ofs}, 32'h0000_0000);
        // twos complement format: zero code lands as offset binary midscale
        fmt <= 1'b1;
        repeat (4) @(posedge pclk);
        wr(12'h140, 32'h0000_0000);
        repeat (2) @(negedge pclk);
        check(latch[0], 32'h0000_2000);
        rd(12'h140, 32'h0000_0000);
        rd(12'h000, 32'h0000_0004);
        check(pslverr, 32'h0000_0000);
        wrap_up();
    end
endmodule : tb_top
bind dcc_core dcc_core_chk i_chk (.*);
